// [src/frs_pkg.sv]
// constants and types shared by the fundamental reset init sequencer
package frs_pkg;

  // core clock rate and sequence time budgets, times in microseconds
  localparam int unsigned CORE_CLK_MHZ = 125;
  localparam int unsigned LINK_TRAIN_US = 20000;
  localparam int unsigned RETRY_READY_US = 100000;
  localparam int unsigned EEPROM_LOAD_US = 200000;
  localparam int unsigned NORMAL_OP_US = 1000000;

  // budgets as whole core clock cycles (longest times, so rounded down)
  localparam int unsigned LINK_TRAIN_CYC = (LINK_TRAIN_US * CORE_CLK_MHZ) / 1;
  localparam int unsigned RETRY_READY_CYC = (RETRY_READY_US * CORE_CLK_MHZ) / 1;
  localparam int unsigned EEPROM_LOAD_CYC = (EEPROM_LOAD_US * CORE_CLK_MHZ) / 1;
  localparam int unsigned NORMAL_OP_CYC = (NORMAL_OP_US * CORE_CLK_MHZ) / 1;

  // master smbus rates in kHz
  localparam int unsigned SLOW_RATE_KHZ = 100;
  localparam int unsigned FAST_RATE_KHZ = 400;

  // strap field widths and positions inside the synchronised strap vector
  localparam int unsigned ADDR_STRAP_W = 4;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned STRAP_W = 10;
  localparam int unsigned POS_SLOW = 0;
  localparam int unsigned POS_ADDR = 1;
  localparam int unsigned POS_MODE = 5;
  localparam int unsigned POS_HALT = 9;
  localparam logic [STRAP_W-1:0] STRAP_RST = 10'h000;

  // slave address: straps land on address bits 5, 3, 2 and 1
  localparam int unsigned SADDR_W = 7;
  localparam logic [SADDR_W-1:0] SADDR_BASE = 7'h00;

  // operating mode that asks for serial eeprom initialisation
  localparam logic [MODE_W-1:0] MODE_EEPROM_INIT = 4'h1;

  // eeprom error code field and the code used for a load overrun
  localparam int unsigned ERR_W = 4;
  localparam logic [ERR_W-1:0] ERR_NONE = 4'h0;
  localparam logic [ERR_W-1:0] ERR_TIMEOUT = 4'hF;

  // sequencer states
  typedef enum logic [3:0] {
    ST_WAIT_CLEAR = 4'h0,
    ST_RATE = 4'h1,
    ST_SLAVE_INIT = 4'h2,
    ST_MASTER_INIT = 4'h3,
    ST_EE_LOAD = 4'h4,
    ST_HALT_CHECK = 4'h5,
    ST_HALTED = 4'h6,
    ST_NORMAL = 4'h7,
    ST_SOFT_FUNDAMENTAL_RESET_CPL = 4'h8
  } frs_state_t;

endpackage

// [src/frs_strap_if.sv]
// carrier for the boot straps sampled at reset pin release
`timescale 1ns/10ps
`default_nettype none
interface frs_strap_if;
  import frs_pkg::*;
  logic resetActive;
  logic resetReleased;
  logic slowRate;
  logic [ADDR_STRAP_W-1:0] slaveAddrStraps;
  logic [MODE_W-1:0] opMode;
  logic haltRequest;

  modport sampler (
    output resetActive,
    output resetReleased,
    output slowRate,
    output slaveAddrStraps,
    output opMode,
    output haltRequest
  );

  modport seq (
    input resetActive,
    input resetReleased,
    input slowRate,
    input slaveAddrStraps,
    input opMode,
    input haltRequest
  );
endinterface
`default_nettype wire

// [src/frs_strap_sampler.sv]
// synchronises the reset pin and straps, captures straps on pin release
`timescale 1ns/10ps
`default_nettype none
module frs_strap_sampler (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins
  input wire logic reset_pin_n,
  input wire logic [frs_pkg::STRAP_W-1:0] strapPins,
  // sampled values
  frs_strap_if.sampler straps
);
  import frs_pkg::*;

  logic [STRAP_W:0] pinsIn;
  logic [STRAP_W:0] syncA;
  logic [STRAP_W:0] syncB;
  logic pinHighDly;
  logic [STRAP_W-1:0] held;
  logic [STRAP_W-1:0] next_held;

  // two-stage synchroniser per pin, the pin level sits on the top bit
  assign pinsIn = {reset_pin_n, strapPins};
  genvar g;
  generate
    for (g = 0; g <= STRAP_W; g++)
    begin : gSync
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
        end
        else
        begin
          syncA[g] <= pinsIn[g];
          syncB[g] <= syncA[g];
        end
      end
    end
  endgenerate

  // capture on the release edge only; a soft reset keeps the old values
  always_comb
  begin
    next_held = held;
    if (syncB[STRAP_W] && !pinHighDly)
      next_held = syncB[STRAP_W-1:0];
  end

  // register the captured straps and the delayed pin level
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      held <= STRAP_RST;
      pinHighDly <= 1'b0;
    end
    else
    begin
      held <= next_held;
      pinHighDly <= syncB[STRAP_W];
    end
  end

  // drive the carrier; halt request shows the fresh capture on the release edge
  assign straps.resetActive = !syncB[STRAP_W];
  assign straps.resetReleased = syncB[STRAP_W] && !pinHighDly;
  assign straps.slowRate = held[POS_SLOW];
  assign straps.slaveAddrStraps = held[POS_ADDR +: ADDR_STRAP_W];
  assign straps.opMode = held[POS_MODE +: MODE_W];
  assign straps.haltRequest = next_held[POS_HALT];
endmodule
`default_nettype wire

// [src/frs_elapsed_timer.sv]
// saturating count of core cycles since the reset condition cleared
`timescale 1ns/10ps
`default_nettype none
module frs_elapsed_timer #(
  parameter int unsigned WIDTH = 27
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control and count
  input wire logic clear,
  output logic [WIDTH-1:0] elapsed
);
  logic [WIDTH-1:0] next_elapsed;

  // hold at all ones so late checks never wrap back to early
  always_comb
  begin
    next_elapsed = elapsed;
    if (clear)
      next_elapsed = '0;
    else if (elapsed != {WIDTH{1'b1}})
      next_elapsed = elapsed + 1'b1;
  end

  // register the count
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      elapsed <= '0;
    else
      elapsed <= next_elapsed;
  end
endmodule
`default_nettype wire

// [src/frs_init_sequencer.sv]
// fundamental reset init sequencer: smbus bring-up, eeprom load, halt
//
// Summary of operation
// - slow-rate strap set gives 100 kHz master smbus, otherwise 400 kHz
// - next release slave smbus, address from straps on bits 5 and 3:1
// - master smbus released only after slave smbus init is done
// - eeprom mode: load eeprom over master smbus into registers
// - load error aborts, sets halt bit and records error code
// - eeprom done flag set on success and on error
// - halted: core logic in reset, smbus and registers alive, stacks retry
// - halt lasts until the halt bit is cleared through slave smbus
// - halted: external agent may reach all registers and eeprom interface
// - normal operation within 1.0 s when eeprom load ends within 200 ms; code only flags a miss on normalDeadlineMissed
// - side effect of an eeprom-loaded write fires at that write
// - soft reset write gets its completion before warm reset starts
// - straps sampled at reset pin release, soft reset reuses them
// - halt pin seen during reset sets the halt status bit
// - quasi-reset: training within 20 ms, config retry within 100 ms
`timescale 1ns/10ps
`default_nettype none
module frs_init_sequencer #(
  parameter int unsigned EEPROM_LOAD_CYC = frs_pkg::EEPROM_LOAD_CYC,
  parameter int unsigned NORMAL_OP_CYC = frs_pkg::NORMAL_OP_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // reset and boot strap pins
  input wire logic reset_pin_n,
  input wire logic master_smbus_slow_strap,
  input wire logic [frs_pkg::ADDR_STRAP_W-1:0] slave_smbus_addr_straps,
  input wire logic [frs_pkg::MODE_W-1:0] operating_mode_straps,
  input wire logic reset_halt,
  // soft fundamental reset write and its completion
  input wire logic softResetWrite,
  input wire logic softResetData,
  output logic softResetCompletion,
  // slave smbus controller
  output logic slaveSmbusRstN,
  output logic [frs_pkg::SADDR_W-1:0] slaveSmbusAddr,
  input wire logic slaveInitDone,
  // master smbus controller
  output logic masterSmbusRstN,
  output logic masterSmbusSlow,
  input wire logic masterInitDone,
  // eeprom loader
  output logic eepromLoadReq,
  output logic eepromLoadAbort,
  input wire logic eepromLoadFinish,
  input wire logic eepromLoadError,
  input wire logic [frs_pkg::ERR_W-1:0] eepromErrorCode,
  input wire logic eeCfgWrite,
  input wire logic eeCfgWriteSideEffect,
  input wire logic eeSetHalt,
  output logic sideEffectFire,
  // halt control from the slave smbus
  input wire logic smbHaltClear,
  // switch control and status bits
  output logic haltBit,
  output logic haltStatus,
  output logic eeprom_load_done,
  output logic eepromErrorFlag,
  output logic [frs_pkg::ERR_W-1:0] eepromErrorRecord,
  // core and stack control
  output logic coreResetN,
  output logic stackResetN,
  output logic linkTrainEnable,
  output logic configRetry,
  output logic agentAccessGrant,
  output logic normalOperation,
  output logic normalDeadlineMissed,
  output frs_pkg::frs_state_t seqState
);
  import frs_pkg::*;

  localparam int unsigned CNT_W = $clog2(NORMAL_OP_CYC + 1);

  // refuse budgets that the sequence cannot keep in order
  generate
    if (EEPROM_LOAD_CYC < 1 || NORMAL_OP_CYC <= EEPROM_LOAD_CYC)
    begin : gBadBudget
      $error("eeprom budget must be nonzero and below the normal-op budget");
    end
    if (LINK_TRAIN_CYC > RETRY_READY_CYC)
    begin : gBadOrder
      $error("link training budget exceeds the retry budget");
    end
  endgenerate

  frs_strap_if straps ();

  frs_state_t state;
  frs_state_t next_state;
  logic next_haltBit;
  logic next_haltStatus;
  logic next_done;
  logic next_errFlag;
  logic [ERR_W-1:0] next_errRecord;
  logic next_masterSlow;
  logic next_sideEffect;
  logic next_deadlineMissed;
  logic [CNT_W-1:0] loadStamp;
  logic [CNT_W-1:0] next_loadStamp;
  logic [CNT_W-1:0] elapsed;
  logic [CNT_W-1:0] loadElapsed;
  logic timerClear;
  logic needsEeprom;
  logic loadOverrun;
  logic loadFail;
  logic haltSetEvent;
  logic softResetHit;

  // pin synchronisers and strap capture
  frs_strap_sampler uSampler (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reset_pin_n(reset_pin_n),
    .strapPins({reset_halt, operating_mode_straps, slave_smbus_addr_straps,
                master_smbus_slow_strap}),
    .straps(straps.sampler)
  );

  // time since the reset condition cleared
  frs_elapsed_timer #(
    .WIDTH(CNT_W)
  ) uTimer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(timerClear),
    .elapsed(elapsed)
  );

  // decode of the sampled mode and eeprom load outcomes
  assign timerClear = (state == ST_WAIT_CLEAR) || (state == ST_SOFT_FUNDAMENTAL_RESET_CPL);
  assign needsEeprom = (straps.opMode == MODE_EEPROM_INIT);
  assign loadElapsed = elapsed - loadStamp;
  assign loadOverrun = (loadElapsed >= CNT_W'(EEPROM_LOAD_CYC));
  assign loadFail = (state == ST_EE_LOAD) && (eepromLoadError || loadOverrun);
  assign haltSetEvent = loadFail || ((state == ST_EE_LOAD) && eeSetHalt);
  assign softResetHit = softResetWrite && softResetData;

  // sequence state and status bits
  always_comb
  begin
    next_state = state;
    next_haltBit = haltBit;
    next_haltStatus = haltStatus;
    next_done = eeprom_load_done;
    next_errFlag = eepromErrorFlag;
    next_errRecord = eepromErrorRecord;
    next_masterSlow = masterSmbusSlow;
    next_loadStamp = loadStamp;
    next_deadlineMissed = normalDeadlineMissed;
    next_sideEffect = (state == ST_EE_LOAD) && eeCfgWrite && eeCfgWriteSideEffect;

    // halt bit: agent clears over slave smbus, a set in the same cycle wins
    if (haltSetEvent)
      next_haltBit = 1'b1;
    else if (smbHaltClear)
      next_haltBit = 1'b0;

    // budget watch: not in normal operation by the deadline
    if (!timerClear && state != ST_NORMAL && elapsed >= CNT_W'(NORMAL_OP_CYC))
      next_deadlineMissed = 1'b1;

    unique case (state)
      ST_WAIT_CLEAR:
      begin
        next_haltBit = 1'b0;
        next_done = 1'b0;
        next_errFlag = 1'b0;
        next_errRecord = ERR_NONE;
        next_deadlineMissed = 1'b0;
        if (!straps.resetActive)
        begin
          next_haltStatus = straps.haltRequest;
          next_state = ST_RATE;
        end
      end
      ST_RATE:
      begin
        next_masterSlow = straps.slowRate;
        next_state = ST_SLAVE_INIT;
      end
      ST_SLAVE_INIT:
      begin
        if (slaveInitDone)
          next_state = ST_MASTER_INIT;
      end
      ST_MASTER_INIT:
      begin
        if (masterInitDone)
        begin
          next_loadStamp = elapsed;
          next_state = needsEeprom ? ST_EE_LOAD : ST_HALT_CHECK;
        end
      end
      ST_EE_LOAD:
      begin
        if (loadFail)
        begin
          next_done = 1'b1;
          next_errFlag = 1'b1;
          next_errRecord = eepromLoadError ? eepromErrorCode : ERR_TIMEOUT;
          next_state = ST_HALT_CHECK;
        end
        else if (eepromLoadFinish)
        begin
          next_done = 1'b1;
          next_state = ST_HALT_CHECK;
        end
      end
      ST_HALT_CHECK:
      begin
        next_state = haltBit ? ST_HALTED : ST_NORMAL;
      end
      ST_HALTED:
      begin
        if (!haltBit)
          next_state = ST_NORMAL;
      end
      ST_NORMAL:
      begin
        next_state = ST_NORMAL;
      end
      ST_SOFT_FUNDAMENTAL_RESET_CPL:
      begin
        next_state = ST_WAIT_CLEAR;
      end
      default:
      begin
        next_state = ST_WAIT_CLEAR;
      end
    endcase

    // soft reset: answer the write first, then restart the sequence
    if (softResetHit && state != ST_WAIT_CLEAR && state != ST_SOFT_FUNDAMENTAL_RESET_CPL)
      next_state = ST_SOFT_FUNDAMENTAL_RESET_CPL;
    // the reset pin overrides everything
    if (straps.resetActive)
      next_state = ST_WAIT_CLEAR;
  end

  // register the sequence state and status
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_WAIT_CLEAR;
      haltBit <= 1'b0;
      haltStatus <= 1'b0;
      eeprom_load_done <= 1'b0;
      eepromErrorFlag <= 1'b0;
      eepromErrorRecord <= ERR_NONE;
      masterSmbusSlow <= 1'b0;
      loadStamp <= '0;
      sideEffectFire <= 1'b0;
      normalDeadlineMissed <= 1'b0;
    end
    else
    begin
      state <= next_state;
      haltBit <= next_haltBit;
      haltStatus <= next_haltStatus;
      eeprom_load_done <= next_done;
      eepromErrorFlag <= next_errFlag;
      eepromErrorRecord <= next_errRecord;
      masterSmbusSlow <= next_masterSlow;
      loadStamp <= next_loadStamp;
      sideEffectFire <= next_sideEffect;
      normalDeadlineMissed <= next_deadlineMissed;
    end
  end

  // smbus controller releases, in order slave then master
  assign slaveSmbusRstN = !timerClear && (state != ST_RATE);
  assign masterSmbusRstN = slaveSmbusRstN && (state != ST_SLAVE_INIT);

  // slave address: straps on bits 5, 3, 2 and 1
  assign slaveSmbusAddr = SADDR_BASE | {1'b0, straps.slaveAddrStraps[3], 1'b0,
                                        straps.slaveAddrStraps[2:0], 1'b0};

  // eeprom load handshake
  assign eepromLoadReq = (state == ST_EE_LOAD);
  assign eepromLoadAbort = loadFail;
  assign softResetCompletion = (state == ST_SOFT_FUNDAMENTAL_RESET_CPL);

  // core held in reset until normal operation, stacks in quasi-reset
  assign coreResetN = (state == ST_NORMAL);
  assign normalOperation = (state == ST_NORMAL);
  assign stackResetN = (state != ST_WAIT_CLEAR);
  assign linkTrainEnable = stackResetN;
  assign configRetry = stackResetN && (state != ST_NORMAL);
  assign agentAccessGrant = (state == ST_HALTED);
  assign seqState = state;
endmodule
`default_nettype wire

// [verification/frs_seq_checker_properties.sv]
// checker on the init sequencer step order, eeprom load and halt handling
`timescale 1ns/10ps
`default_nettype none
module frs_seq_checker #(
  parameter int unsigned EEPROM_LOAD_CYC = 50,
  parameter int unsigned NORMAL_OP_CYC = 200
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // straps and soft reset
  input wire logic master_smbus_slow_strap,
  input wire logic [frs_pkg::MODE_W-1:0] operating_mode_straps,
  input wire logic softResetWrite,
  input wire logic softResetData,
  input wire logic softResetCompletion,
  // smbus controllers
  input wire logic slaveSmbusRstN,
  input wire logic slaveInitDone,
  input wire logic masterSmbusRstN,
  input wire logic masterSmbusSlow,
  input wire logic masterInitDone,
  // eeprom loader
  input wire logic eepromLoadReq,
  input wire logic eepromLoadAbort,
  input wire logic eepromLoadFinish,
  input wire logic eepromLoadError,
  input wire logic [frs_pkg::ERR_W-1:0] eepromErrorCode,
  input wire logic eeCfgWrite,
  input wire logic eeCfgWriteSideEffect,
  input wire logic sideEffectFire,
  // halt and status
  input wire logic smbHaltClear,
  input wire logic haltBit,
  input wire logic eeprom_load_done,
  input wire logic eepromErrorFlag,
  input wire logic [frs_pkg::ERR_W-1:0] eepromErrorRecord,
  input wire logic coreResetN,
  input wire logic agentAccessGrant,
  input wire frs_pkg::frs_state_t seqState
);
  import frs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // step order of the smbus bring-up
  a_rate_pick: assert property ($rose(slaveSmbusRstN) |-> !masterSmbusRstN &&
    masterSmbusSlow == master_smbus_slow_strap) else $error("rate or slave order wrong");
  a_master_order: assert property ($rose(masterSmbusRstN) |-> slaveSmbusRstN &&
    $past(slaveInitDone)) else $error("master released before slave init");
  a_load_choice: assert property (seqState == ST_MASTER_INIT && masterInitDone |=>
    seqState == (operating_mode_straps == MODE_EEPROM_INIT ? ST_EE_LOAD : ST_HALT_CHECK))
    else $error("wrong step after master init");
  // eeprom load end and side effects
  a_error_abort: assert property (eepromLoadReq && eepromLoadError |-> eepromLoadAbort ##1
    (haltBit && eepromErrorFlag && eepromErrorRecord == $past(eepromErrorCode)))
    else $error("load error not handled");
  a_done_flag: assert property (eepromLoadReq && (eepromLoadFinish || eepromLoadError) |=>
    eeprom_load_done && !eepromLoadReq) else $error("done flag missing");
  a_side_fire: assert property (eepromLoadReq && eeCfgWrite && eeCfgWriteSideEffect |=>
    sideEffectFire) else $error("side effect not fired");
  // halt state
  a_halted_hold: assert property (seqState == ST_HALTED |-> agentAccessGrant && !coreResetN &&
    slaveSmbusRstN && masterSmbusRstN) else $error("halted state outputs wrong");
  a_halt_stay: assert property (seqState == ST_HALTED && haltBit && !smbHaltClear &&
    !softResetWrite |=> seqState == ST_HALTED) else $error("left halt without clear");
  a_halt_leave: assert property (seqState == ST_HALTED && smbHaltClear |-> ##[1:2]
    coreResetN) else $error("halt clear not honoured");
  // soft reset completion
  a_soft_cpl: assert property (softResetWrite && softResetData &&
    !(seqState inside {ST_WAIT_CLEAR, ST_SOFT_FUNDAMENTAL_RESET_CPL}) |=> softResetCompletion && !coreResetN
    ##1 seqState == ST_WAIT_CLEAR) else $error("soft reset completion wrong");
endmodule

bind frs_init_sequencer frs_seq_checker #(
  .EEPROM_LOAD_CYC(EEPROM_LOAD_CYC),
  .NORMAL_OP_CYC(NORMAL_OP_CYC)
) chk (.*);
`default_nettype wire

// [verification/frs_agent_model.sv]
// smbus controllers, eeprom and external agent standing beside the sequencer
`timescale 1ns/10ps
`default_nettype none
module frs_agent_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // answer delay and eeprom outcome: 0 ok, 1 error, 2 hang, 3 sets halt
  input wire logic [5:0] lat,
  input wire logic [1:0] eeMode,
  // sequencer levels watched
  input wire logic slaveSmbusRstN,
  input wire logic masterSmbusRstN,
  input wire logic eepromLoadReq,
  input wire logic agentAccessGrant,
  // answers
  output logic slaveInitDone,
  output logic masterInitDone,
  output logic eepromLoadFinish,
  output logic eepromLoadError,
  output logic [frs_pkg::ERR_W-1:0] eepromErrorCode,
  output logic eeCfgWrite,
  output logic eeCfgWriteSideEffect,
  output logic eeSetHalt,
  output logic smbHaltClear
);
  import frs_pkg::*;
  logic [3:0] phase;
  logic [3:0] lastPhase;
  logic [7:0] cnt;
  logic ee;
  logic at;
  assign phase = {agentAccessGrant, eepromLoadReq, masterSmbusRstN, slaveSmbusRstN};
  assign ee = phase == 4'h7;
  assign at = cnt == {2'h0, lat};
  // count cycles in the present phase and answer after lat of them
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      {lastPhase, cnt, slaveInitDone, masterInitDone, eeCfgWrite} <= '0;
      {eeCfgWriteSideEffect, eeSetHalt, eepromLoadFinish, eepromLoadError} <= '0;
      {smbHaltClear, eepromErrorCode} <= '0;
    end
    else
    begin
      lastPhase <= phase;
      cnt <= (phase == lastPhase && cnt != 8'hFF) ? cnt + 8'h01 : 8'h00;
      slaveInitDone <= phase == 4'h1 && at;
      masterInitDone <= phase == 4'h3 && at;
      eeCfgWrite <= ee && (cnt == 8'h01 || cnt == 8'h02);
      eeCfgWriteSideEffect <= ee && cnt == 8'h02;
      eeSetHalt <= ee && cnt == 8'h01 && eeMode == 2'h3;
      eepromLoadFinish <= ee && at && eeMode[0] == eeMode[1];
      eepromLoadError <= ee && at && eeMode == 2'h1;
      eepromErrorCode <= (ee && at && eeMode == 2'h1) ? 4'h5 : 4'hA; // idle shows inverse
      smbHaltClear <= phase[3] && at;
    end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the fundamental reset init sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import frs_pkg::*;
  typedef struct packed {
    logic slow;
    logic [3:0] mode;
    logic [1:0] ee;
    logic hp;
  } frs_row_t;
  localparam int NROW = 6;
  localparam frs_row_t ROWS [NROW] = '{'{1'b1, 4'h0, 2'h0, 1'b1}, '{1'b0, 4'h1, 2'h0, 1'b0},
    '{1'b1, 4'h1, 2'h1, 1'b0}, '{1'b0, 4'h1, 2'h2, 1'b1}, '{1'b0, 4'h1, 2'h3, 1'b0},
    '{1'b1, 4'h2, 2'h1, 1'b0}};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b0;
  logic master_smbus_slow_strap = 1'b0;
  logic reset_halt = 1'b0;
  logic softResetWrite = 1'b0;
  logic softResetData = 1'b0;
  logic [3:0] slave_smbus_addr_straps = 4'h0;
  logic [3:0] operating_mode_straps = 4'h0;
  logic [5:0] lat = 6'h03;
  logic [1:0] eeMode = 2'h0;
  logic slaveInitDone, masterInitDone, eepromLoadFinish, eepromLoadError, eeCfgWrite;
  logic eeCfgWriteSideEffect, eeSetHalt, smbHaltClear, softResetCompletion, linkTrainEnable;
  logic [3:0] eepromErrorCode, eepromErrorRecord;
  logic slaveSmbusRstN, masterSmbusRstN, masterSmbusSlow, eepromLoadReq, eepromLoadAbort;
  logic haltBit, haltStatus, eeprom_load_done, eepromErrorFlag, coreResetN, agentAccessGrant;
  logic normalOperation, normalDeadlineMissed, sideEffectFire, stackResetN, configRetry;
  logic [6:0] slaveSmbusAddr;
  frs_state_t seqState;
  int error_cnt = 0;
  int n_checks = 0;
  int fires;
  logic sawHalt;

  frs_init_sequencer #(.EEPROM_LOAD_CYC(50), .NORMAL_OP_CYC(200)) DUT (.*);
  frs_agent_model model (.*);

  always #4 core_clk = ~core_clk;

  // compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // print counts and verdict, then stop
  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // wait for normal operation, noting halt and side effects on the way
  task automatic wait_normal;
    sawHalt = 1'b0;
    fires = 0;
    for (int n = 0; n < 400 && normalOperation !== 1'b1; n++)
    begin
      @(negedge core_clk);
      if (agentAccessGrant === 1'b1) sawHalt = 1'b1;
      if (sideEffectFire === 1'b1) fires++;
    end
    chk(normalOperation, 1'b1);
  endtask

  // main sequence: reset, table rows, a budget overrun case, then soft reset cases
  initial
  begin
    frs_row_t r;
    logic [3:0] addr;
    logic err;
    repeat (2) @(negedge core_clk);
    chk({coreResetN, slaveSmbusRstN, masterSmbusRstN, eepromLoadReq}, 8'h00);
    rst_n = 1'b1;
    for (int i = 0; i < NROW; i++)
    begin
      r = ROWS[i];
      addr = 4'(3 * i + 5);
      reset_pin_n = 1'b0;
      {master_smbus_slow_strap, operating_mode_straps, eeMode, reset_halt} = r;
      slave_smbus_addr_straps = addr;
      lat = 6'(3 + 5 * i);
      repeat (4) @(negedge core_clk);
      reset_pin_n = 1'b1;
      wait_normal();
      err = r.mode == MODE_EEPROM_INIT && (r.ee == 2'h1 || r.ee == 2'h2);
      chk(masterSmbusSlow, r.slow);
      chk(slaveSmbusAddr, {1'b0, addr[3], 1'b0, addr[2:0], 1'b0} | SADDR_BASE);
      chk(eeprom_load_done, r.mode == MODE_EEPROM_INIT);
      chk(eepromErrorFlag, err);
      chk(eepromErrorRecord, !err ? ERR_NONE : (r.ee == 2'h1 ? 4'h5 : ERR_TIMEOUT));
      chk(sawHalt, err || (r.mode == MODE_EEPROM_INIT && r.ee == 2'h3));
      chk(8'(fires), r.mode == MODE_EEPROM_INIT);
      chk(haltStatus, r.hp);
      chk(haltBit, 1'b0);
      chk(normalDeadlineMissed, 1'b0);
      chk({stackResetN, linkTrainEnable, configRetry}, 8'h06);
    end
    // slow answers and a hung load overrun the normal-operation budget
    reset_pin_n = 1'b0;
    operating_mode_straps = MODE_EEPROM_INIT;
    eeMode = 2'h2;
    lat = 6'h3F;
    repeat (4) @(negedge core_clk);
    reset_pin_n = 1'b1;
    repeat (10) @(negedge core_clk);
    chk({stackResetN, linkTrainEnable, configRetry, coreResetN}, 8'h0E);
    wait_normal();
    chk(normalDeadlineMissed, 1'b1);
    chk(eepromErrorRecord, ERR_TIMEOUT);
    // a write of zero to the soft reset bit leaves the device running
    softResetWrite = 1'b1;
    @(negedge core_clk);
    softResetWrite = 1'b0;
    chk(seqState, ST_NORMAL);
    @(negedge core_clk);
    // a write of one completes first and keeps the old straps
    slave_smbus_addr_straps = ~addr;
    softResetWrite = 1'b1;
    softResetData = 1'b1;
    @(negedge core_clk);
    softResetWrite = 1'b0;
    chk(softResetCompletion, 1'b1);
    chk(coreResetN, 1'b0);
    chk(stackResetN, 1'b1);
    wait_normal();
    chk(slaveSmbusAddr, {1'b0, addr[3], 1'b0, addr[2:0], 1'b0} | SADDR_BASE);
    end_sim();
  end

  // watchdog against a hung sequence
  initial
  begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
